// ### sfo_pkg.sv
package sfo_pkg;
    // Storage geometry.
    localparam int DEPTH = 32;
    localparam int IDX_W = 5;
    localparam int ELEM_W = 24;
    localparam int ELEMS = 4;
    localparam int ADDR_W = 7;
    localparam logic [4:0] LOST_MAX = 5'h1F;
    localparam logic [4:0] IDX_RST = 5'h00;
    localparam logic [4:0] LOST_RST = 5'h00;
    localparam logic [3:0] THR_RST = 4'h0;
    // Burst read sources: which value the host byte port presents.
    typedef enum logic [1:0] {
        SFO_SRC_WIDX = 2'b00,
        SFO_SRC_LOST = 2'b01,
        SFO_SRC_RIDX = 2'b11,
        SFO_SRC_DATA = 2'b10
    } sfo_src_e;
    // One acquired sample from the front ends.
    typedef struct packed {
        logic [ELEMS*ELEM_W-1:0] elem;
    } sfo_sample_s;
    // Flush triggers from the register bank.
    typedef struct packed {
        logic cfg_write;
        logic prox_mode;
    } sfo_flush_s;
endpackage

// ### sfo_fifo.sv
`timescale 1ns/100ps
// Summary of operation
// - Sample bytes go out element by element, MSB first; index holds until sample done.
// - Full with overwrite set drops oldest; otherwise new samples are dropped.
// - Five-bit lost counter counts dropped samples and saturates at 0x1F.
// - Lost counter clears when a host read pops a sample, and on flush; an overwrite advance does not clear it.
// - Four-bit threshold sets free space that counts as almost full.
// - Almost-full sets a status flag; interrupt only when its enable is set.
// - Reading the status register clears the almost-full flag.
// - Burst from write index returns write index, lost count, read index.
// - Data register reads give successive buffer bytes without address step.
// - Read index is writable so the host can replay samples.
// - While enabled, flush on config writes, enable rising edge, proximity change.
// - Flush zeroes both indices and discards contents.
// - Push only while enabled; disabled keeps write index and data, while host pops and rewinds still move the read index.
// - Storage is 128 words of 24 bits, four words per sample slot.
module sfo_fifo (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic LINK_CLK,
    input wire sfo_pkg::sfo_sample_s SAMPLE,
    input wire logic SAMPLE_VALID,
    input wire logic [2:0] ELEM_COUNT,
    input wire logic FIFO_ENABLE,
    input wire logic OVERWRITE_WHEN_FULL,
    input wire logic [3:0] ALMOST_FULL_THRESHOLD,
    input wire logic ALMOST_FULL_IRQ_ENABLE,
    input wire sfo_pkg::sfo_flush_s FLUSH_IN,
    input wire logic STATUS_READ,
    input wire logic [1:0] HOST_SRC,
    input wire logic HOST_BYTE_REQ,
    input wire logic HOST_RIDX_WR,
    input wire logic [4:0] HOST_RIDX_DATA,
    output logic [7:0] HOST_BYTE,
    output logic HOST_BYTE_VALID,
    output logic [4:0] SAMPLE_WRITE_INDEX,
    output logic [4:0] SAMPLE_READ_INDEX,
    output logic [4:0] LOST_SAMPLE_COUNT,
    output logic ALMOST_FULL,
    output logic ALMOST_FULL_IRQ
);
    logic [sfo_pkg::ELEM_W-1:0] mem [0:(1<<sfo_pkg::ADDR_W)-1];
    logic [4:0] widx_q, ridx_q, lost_q;
    logic [5:0] count_q;
    logic afull_q;
    logic [1:0] elem_q, byte_q;
    logic [2:0] en_sync_q, prox_sync_q;
    logic en_prev_q, prox_prev_q;
    logic en_lvl_q, prox_lvl_q;
    logic flush, push, pop, full, wr_ok;
    logic [5:0] free_slots;

    // Link-side request crossing: toggle in link domain, three-stage sync here.
    logic req_tgl_lq, rwr_tgl_lq;
    logic [4:0] rwr_data_lq;
    logic [1:0] src_lq;
    logic [2:0] req_sync_q, rwr_sync_q;
    logic req_ev, rwr_ev;
    logic [7:0] byte_q_out;
    logic [2:0] ack_sync_lq;
    logic ack_tgl_q;

    // Requests are captured on the link clock and held stable until acknowledged.
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            req_tgl_lq <= 1'b0;
            rwr_tgl_lq <= 1'b0;
            rwr_data_lq <= sfo_pkg::IDX_RST;
            src_lq <= 2'b00;
        end else begin
            if (HOST_BYTE_REQ) begin
                req_tgl_lq <= ~req_tgl_lq;
                src_lq <= HOST_SRC;
            end
            if (HOST_RIDX_WR) begin
                rwr_tgl_lq <= ~rwr_tgl_lq;
                rwr_data_lq <= HOST_RIDX_DATA;
            end
        end
    end

    // Answer toggles come back and are synchronised into the link domain.
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_sync_lq <= 3'b000;
        end else begin
            ack_sync_lq <= {ack_sync_lq[1:0], ack_tgl_q};
        end
    end
    assign HOST_BYTE_VALID = ack_sync_lq[2] ^ ack_sync_lq[1];
    assign HOST_BYTE = byte_q_out;

    // Three-stage synchronisers; second and third stages are compared.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            req_sync_q <= 3'b000;
            rwr_sync_q <= 3'b000;
            en_sync_q <= 3'b000;
            prox_sync_q <= 3'b000;
        end else begin
            req_sync_q <= {req_sync_q[1:0], req_tgl_lq};
            rwr_sync_q <= {rwr_sync_q[1:0], rwr_tgl_lq};
            en_sync_q <= {en_sync_q[1:0], FIFO_ENABLE};
            prox_sync_q <= {prox_sync_q[1:0], FLUSH_IN.prox_mode};
        end
    end
    assign req_ev = req_sync_q[2] ^ req_sync_q[1];
    assign rwr_ev = rwr_sync_q[2] ^ rwr_sync_q[1];

    // A level change counts only once the last two stages agree, so a runt pulse that
    // reaches only one of them cannot start a flush.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_lvl_q <= 1'b0;
            prox_lvl_q <= 1'b0;
        end else begin
            if (en_sync_q[2] == en_sync_q[1]) begin
                en_lvl_q <= en_sync_q[2];
            end
            if (prox_sync_q[2] == prox_sync_q[1]) begin
                prox_lvl_q <= prox_sync_q[2];
            end
        end
    end

    // Edge history of the filtered enable and proximity levels.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_prev_q <= 1'b0;
            prox_prev_q <= 1'b0;
        end else begin
            en_prev_q <= en_lvl_q;
            prox_prev_q <= prox_lvl_q;
        end
    end

    // Flush causes, all qualified by the enable bit being set.
    assign flush = en_lvl_q & (FLUSH_IN.cfg_write | ~en_prev_q
                   | (prox_lvl_q ^ prox_prev_q));
    assign full = (count_q == 6'(sfo_pkg::DEPTH));
    assign push = SAMPLE_VALID & en_lvl_q & ~flush;
    assign wr_ok = push & (~full | OVERWRITE_WHEN_FULL);
    assign free_slots = 6'(sfo_pkg::DEPTH) - count_q;

    // A pop happens on the last byte of the last active element of a sample.
    assign pop = req_ev & (src_lq == 2'(sfo_pkg::SFO_SRC_DATA)) & (byte_q == 2'd2)
                 & ({1'b0, elem_q} == ELEM_COUNT - 3'd1);

    // Each slot owns four consecutive words, so the element number forms the low address bits.
    function automatic logic [sfo_pkg::ADDR_W-1:0] slot_addr(input logic [4:0] idx,
            input logic [1:0] elem);
        return {idx, elem};
    endfunction

    // Storage write: slot index times four plus element number.
    always_ff @(posedge CLK) begin
        if (wr_ok) begin
            for (int e = 0; e < sfo_pkg::ELEMS; e++) begin
                mem[slot_addr(widx_q, 2'(e))] <=
                    SAMPLE.elem[e*sfo_pkg::ELEM_W +: sfo_pkg::ELEM_W];
            end
        end
    end

    // Write index, read index and fill count.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            widx_q <= sfo_pkg::IDX_RST;
            ridx_q <= sfo_pkg::IDX_RST;
            count_q <= 6'h00;
        end else if (flush) begin
            widx_q <= sfo_pkg::IDX_RST;
            ridx_q <= sfo_pkg::IDX_RST;
            count_q <= 6'h00;
        end else if (rwr_ev) begin
            // Host rewind recomputes fill from the index difference.
            ridx_q <= rwr_data_lq;
            count_q <= (widx_q == rwr_data_lq && full) ? count_q
                       : {1'b0, 5'(widx_q - rwr_data_lq)};
        end else begin
            if (wr_ok) begin
                widx_q <= widx_q + 5'd1;
            end
            if ((wr_ok && full && !pop) || (pop && count_q != 6'h00 && !(wr_ok && full))) begin
                ridx_q <= ridx_q + 5'd1;
            end else if (pop && count_q != 6'h00) begin
                ridx_q <= ridx_q + 5'd1;
            end
            // An overwrite in the cycle of a pop refills the freed slot, so the fill holds.
            if (wr_ok && !full && !(pop && count_q != 6'h00)) begin
                count_q <= count_q + 6'h01;
            end else if (pop && count_q != 6'h00 && !wr_ok) begin
                count_q <= count_q - 6'h01;
            end
        end
    end

    // Lost counter: pop clears, drop counts up with saturation.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            lost_q <= sfo_pkg::LOST_RST;
        end else if (flush || (pop && count_q != 6'h00)) begin
            lost_q <= sfo_pkg::LOST_RST;
        end else if (push && full && lost_q != sfo_pkg::LOST_MAX) begin
            lost_q <= lost_q + 5'd1;
        end
    end

    // Byte walker within a sample; rewinds restart at the first byte.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            elem_q <= 2'd0;
            byte_q <= 2'd0;
        end else if (flush || rwr_ev || pop) begin
            elem_q <= 2'd0;
            byte_q <= 2'd0;
        end else if (req_ev && src_lq == 2'(sfo_pkg::SFO_SRC_DATA)) begin
            if (byte_q == 2'd2) begin
                byte_q <= 2'd0;
                elem_q <= elem_q + 2'd1;
            end else begin
                byte_q <= byte_q + 2'd1;
            end
        end
    end

    // Answer byte is registered and the acknowledge toggle flips on the same clock edge.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            byte_q_out <= 8'h00;
            ack_tgl_q <= 1'b0;
        end else if (req_ev) begin
            ack_tgl_q <= ~ack_tgl_q;
            unique case (sfo_pkg::sfo_src_e'(src_lq))
                sfo_pkg::SFO_SRC_WIDX: byte_q_out <= {3'b000, widx_q};
                sfo_pkg::SFO_SRC_LOST: byte_q_out <= {3'b000, lost_q};
                sfo_pkg::SFO_SRC_RIDX: byte_q_out <= {3'b000, ridx_q};
                sfo_pkg::SFO_SRC_DATA: begin
                    byte_q_out <= mem[slot_addr(ridx_q, elem_q)][8*(2-byte_q) +: 8];
                end
            endcase
        end
    end

    // Almost-full flag: set after a push leaves too little room; status read clears.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            afull_q <= 1'b0;
        end else if (wr_ok && (free_slots - 6'(!full)) <= {2'b00, ALMOST_FULL_THRESHOLD}) begin
            afull_q <= 1'b1; // Set beats a simultaneous clear.
        end else if (STATUS_READ || flush) begin
            afull_q <= 1'b0;
        end
    end

    assign SAMPLE_WRITE_INDEX = widx_q;
    assign SAMPLE_READ_INDEX = ridx_q;
    assign LOST_SAMPLE_COUNT = lost_q;
    assign ALMOST_FULL = afull_q;
    assign ALMOST_FULL_IRQ = afull_q & ALMOST_FULL_IRQ_ENABLE;

    // Checks on the system clock domain; the link-side values they read are held stable
    // by the one-outstanding-request handshake.
    chk_lost_saturate: assert property (@(posedge CLK) disable iff (!RST_N)
        (lost_q == sfo_pkg::LOST_MAX && !flush && !pop) |=> lost_q == sfo_pkg::LOST_MAX)
        else $error("lost counter left saturation");
    chk_lost_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        (pop && count_q != 6'h00 && !rwr_ev) |=> lost_q == 5'h00)
        else $error("lost counter not cleared on pop");
    chk_flush_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        flush |=> (widx_q == 5'h00 && ridx_q == 5'h00))
        else $error("flush left indices non-zero");
    chk_hold_disabled: assert property (@(posedge CLK) disable iff (!RST_N)
        (!en_lvl_q && !rwr_ev && !pop) |=> $stable(widx_q) && $stable(ridx_q))
        else $error("indices moved while disabled");
    chk_drop_new: assert property (@(posedge CLK) disable iff (!RST_N)
        (push && full && !OVERWRITE_WHEN_FULL && !rwr_ev) |=> $stable(widx_q))
        else $error("new sample stored while full");
    chk_irq_mask: assert property (@(posedge CLK) disable iff (!RST_N)
        ALMOST_FULL_IRQ |-> (afull_q && ALMOST_FULL_IRQ_ENABLE))
        else $error("irq without flag and enable");
    chk_status_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        (STATUS_READ && !wr_ok) |=> !afull_q)
        else $error("status read did not clear flag");
    chk_rewind: assert property (@(posedge CLK) disable iff (!RST_N)
        (rwr_ev && !flush) |=> ridx_q == $past(rwr_data_lq))
        else $error("read index rewind lost");
    chk_enable_edge: assert property (@(posedge CLK) disable iff (!RST_N)
        (en_lvl_q && !en_prev_q) |=> count_q == 6'h00)
        else $error("enable edge did not flush");
    chk_afull_set: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_ok && ({1'b0, count_q} + {3'h0, ALMOST_FULL_THRESHOLD}) >= 7'h1F) |=> afull_q)
        else $error("almost full not set after push");
    chk_fill_bound: assert property (@(posedge CLK) disable iff (!RST_N)
        count_q <= 6'(sfo_pkg::DEPTH))
        else $error("fill count above depth");
    chk_pop_advance: assert property (@(posedge CLK) disable iff (!RST_N)
        (pop && count_q != 6'h00 && !rwr_ev && !flush) |=> ridx_q == $past(ridx_q) + 5'h01)
        else $error("read index did not advance on pop");
    cov_full_drop: cover property (@(posedge CLK) disable iff (!RST_N) push && full);
    cov_pop: cover property (@(posedge CLK) disable iff (!RST_N) pop);
    cov_afull: cover property (@(posedge CLK) disable iff (!RST_N) $rose(afull_q));
    cov_overwrite: cover property (@(posedge CLK) disable iff (!RST_N) wr_ok && full);
    cov_rewind: cover property (@(posedge CLK) disable iff (!RST_N) rwr_ev);
endmodule

// ### sfo_host.sv
`timescale 1ns/100ps
// Host model: keeps a single byte request outstanding, because a second one would muddle the source.
module sfo_host (
    input wire logic LINK_CLK,
    input wire logic [7:0] HOST_BYTE,
    input wire logic HOST_BYTE_VALID,
    output logic [1:0] HOST_SRC,
    output logic HOST_BYTE_REQ,
    output logic HOST_RIDX_WR,
    output logic [4:0] HOST_RIDX_DATA
);
    // Idle levels before the first request.
    initial begin
        HOST_SRC = 2'h0;
        HOST_BYTE_REQ = 1'b0;
        HOST_RIDX_WR = 1'b0;
        HOST_RIDX_DATA = 5'h1F;
    end
    // Requests one byte and holds the source until the answer; ok stays low on a hang.
    task automatic get_byte(input logic [1:0] src, output logic [7:0] b, output bit ok);
        int n;
        ok = 1'b0;
        b = 8'h00;
        @(posedge LINK_CLK);
        HOST_SRC <= src;
        HOST_BYTE_REQ <= 1'b1;
        @(posedge LINK_CLK);
        HOST_BYTE_REQ <= 1'b0;
        for (n = 0; n < 200 && !ok; n++) begin
            @(posedge LINK_CLK);
            if (HOST_BYTE_VALID === 1'b1) begin
                b = HOST_BYTE;
                ok = 1'b1;
            end
        end
    endtask
    // Writes the read index back; the data lines are then scrambled, not left at the old value.
    task automatic set_ridx(input logic [4:0] v);
        @(posedge LINK_CLK);
        HOST_RIDX_DATA <= v;
        HOST_RIDX_WR <= 1'b1;
        @(posedge LINK_CLK);
        HOST_RIDX_WR <= 1'b0;
        HOST_RIDX_DATA <= ~v;
    endtask
endmodule

// ### sfo_fifo_test.sv
`timescale 1ns/100ps
// Drives samples and controls on the system clock and reads bytes through the host model.
module sfo_fifo_test;
    logic CLK, RST_N, LINK_CLK, SAMPLE_VALID, FIFO_ENABLE, OVERWRITE_WHEN_FULL;
    logic ALMOST_FULL_IRQ_ENABLE, STATUS_READ, HOST_BYTE_REQ, HOST_RIDX_WR, HOST_BYTE_VALID;
    logic ALMOST_FULL, ALMOST_FULL_IRQ;
    logic [1:0] HOST_SRC;
    logic [2:0] ELEM_COUNT;
    logic [4:0] HOST_RIDX_DATA, SAMPLE_WRITE_INDEX, SAMPLE_READ_INDEX, LOST_SAMPLE_COUNT;
    logic [7:0] HOST_BYTE;
    sfo_pkg::sfo_sample_s SAMPLE;
    sfo_pkg::sfo_flush_s FLUSH_IN;
    int fails, n_tests;
    sfo_fifo sfo_fifo_inst (.CLK(CLK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .SAMPLE(SAMPLE),
        .SAMPLE_VALID(SAMPLE_VALID), .ELEM_COUNT(ELEM_COUNT), .FIFO_ENABLE(FIFO_ENABLE),
        .OVERWRITE_WHEN_FULL(OVERWRITE_WHEN_FULL), .ALMOST_FULL_THRESHOLD(4'h4),
        .ALMOST_FULL_IRQ_ENABLE(ALMOST_FULL_IRQ_ENABLE), .FLUSH_IN(FLUSH_IN),
        .STATUS_READ(STATUS_READ), .HOST_SRC(HOST_SRC), .HOST_BYTE_REQ(HOST_BYTE_REQ),
        .HOST_RIDX_WR(HOST_RIDX_WR), .HOST_RIDX_DATA(HOST_RIDX_DATA), .HOST_BYTE(HOST_BYTE),
        .HOST_BYTE_VALID(HOST_BYTE_VALID), .SAMPLE_WRITE_INDEX(SAMPLE_WRITE_INDEX),
        .SAMPLE_READ_INDEX(SAMPLE_READ_INDEX), .LOST_SAMPLE_COUNT(LOST_SAMPLE_COUNT),
        .ALMOST_FULL(ALMOST_FULL), .ALMOST_FULL_IRQ(ALMOST_FULL_IRQ));
    sfo_host sfo_host_inst (.LINK_CLK(LINK_CLK), .HOST_BYTE(HOST_BYTE),
        .HOST_BYTE_VALID(HOST_BYTE_VALID), .HOST_SRC(HOST_SRC), .HOST_BYTE_REQ(HOST_BYTE_REQ),
        .HOST_RIDX_WR(HOST_RIDX_WR), .HOST_RIDX_DATA(HOST_RIDX_DATA));
    // System clock, 40 ns.
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    // Link clock, 6 ns, offset so the two domains never line up.
    initial begin
        LINK_CLK = 1'b0;
        #1.3;
        forever #3 LINK_CLK = ~LINK_CLK;
    end
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Sample k, element e carries k, e and a fixed low byte 0x5A, so the high and mid bytes name the sample and element.
    function automatic sfo_pkg::sfo_sample_s mk(input int k);
        sfo_pkg::sfo_sample_s s;
        for (int e = 0; e < 4; e++) begin
            s.elem[24*e +: 24] = {k[7:0], 8'(e), 8'h5A};
        end
        return s;
    endfunction
    task automatic push(input int k0, input int n);
        for (int k = k0; k < k0 + n; k++) begin
            @(posedge CLK);
            SAMPLE <= mk(k);
            SAMPLE_VALID <= 1'b1;
            @(posedge CLK);
            SAMPLE_VALID <= 1'b0;
        end
        repeat (3) @(posedge CLK);
    endtask
    task automatic idx(input logic [4:0] w, input logic [4:0] r);
        chk("write index", {3'h0, w}, {3'h0, SAMPLE_WRITE_INDEX});
        chk("read index", {3'h0, r}, {3'h0, SAMPLE_READ_INDEX});
    endtask
    task automatic rd(input logic [1:0] src, input logic [7:0] exp, input string what);
        logic [7:0] b;
        bit ok;
        sfo_host_inst.get_byte(src, b, ok);
        if (!ok) begin
            fails++;
            finish_test();
        end else begin
            chk(what, exp, b);
        end
    endtask
    // Three bytes per active element, high byte of each element first.
    task automatic rd_sample(input int k, input int ne);
        for (int e = 0; e < ne; e++) begin
            rd(sfo_pkg::SFO_SRC_DATA, k[7:0], "data high");
            rd(sfo_pkg::SFO_SRC_DATA, 8'(e), "data mid");
            rd(sfo_pkg::SFO_SRC_DATA, 8'h5A, "data low");
        end
        repeat (4) @(posedge CLK);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask
    initial begin
        RST_N = 1'b0;
        SAMPLE = '0;
        SAMPLE_VALID = 1'b0;
        FIFO_ENABLE = 1'b0;
        OVERWRITE_WHEN_FULL = 1'b0;
        ALMOST_FULL_IRQ_ENABLE = 1'b0;
        STATUS_READ = 1'b0;
        FLUSH_IN = '0;
        ELEM_COUNT = 3'h2;
        cyc(2);
        RST_N <= 1'b1;
        cyc(4);
        idx(5'h00, 5'h00);
        FIFO_ENABLE <= 1'b1;
        cyc(8);
        push(0, 27);
        chk("almost full", 8'h00, {7'h0, ALMOST_FULL});
        push(27, 1);
        chk("almost full", 8'h01, {7'h0, ALMOST_FULL});
        chk("interrupt", 8'h00, {7'h0, ALMOST_FULL_IRQ});
        ALMOST_FULL_IRQ_ENABLE <= 1'b1;
        cyc(2);
        chk("interrupt", 8'h01, {7'h0, ALMOST_FULL_IRQ});
        STATUS_READ <= 1'b1;
        cyc(1);
        STATUS_READ <= 1'b0;
        cyc(2);
        chk("almost full", 8'h00, {7'h0, ALMOST_FULL});
        push(28, 44);
        rd(sfo_pkg::SFO_SRC_WIDX, 8'h00, "burst write index");
        rd(sfo_pkg::SFO_SRC_LOST, 8'h1F, "burst lost count");
        rd(sfo_pkg::SFO_SRC_RIDX, 8'h00, "burst read index");
        rd_sample(0, 2);
        idx(5'h00, 5'h01);
        chk("lost count", 8'h00, {3'h0, LOST_SAMPLE_COUNT});
        OVERWRITE_WHEN_FULL <= 1'b1;
        push(72, 2);
        idx(5'h02, 5'h02);
        rd_sample(2, 2);
        sfo_host_inst.set_ridx(5'h01);
        cyc(6);
        rd_sample(73, 2);
        idx(5'h02, 5'h02);
        FIFO_ENABLE <= 1'b0;
        cyc(8);
        push(80, 1);
        idx(5'h02, 5'h02);
        FIFO_ENABLE <= 1'b1;
        cyc(8);
        idx(5'h00, 5'h00);
        push(81, 3);
        FLUSH_IN.cfg_write <= 1'b1;
        cyc(1);
        FLUSH_IN.cfg_write <= 1'b0;
        cyc(3);
        idx(5'h00, 5'h00);
        push(84, 3);
        FLUSH_IN.prox_mode <= 1'b1;
        cyc(8);
        idx(5'h00, 5'h00);
        ELEM_COUNT <= 3'h3;
        push(90, 1);
        rd_sample(90, 3);
        idx(5'h01, 5'h01);
        FIFO_ENABLE <= 1'b0;
        cyc(8);
        FLUSH_IN.cfg_write <= 1'b1;
        cyc(1);
        FLUSH_IN.cfg_write <= 1'b0;
        cyc(3);
        idx(5'h01, 5'h01);
        finish_test();
    end
endmodule
